//--- hdl/txrx_pkg.sv
/*
  Shared constants and types of the serial transceiver datapath: register offsets,
  field positions, reset values, frame-length codes, state enums and carrier structs.
  Assumes an 8-bit register port with a 2-bit word address.
*/
package txrx_pkg;

  // ==========================================================================
  // register port
  localparam int ADDR_W = 2;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_DATA = 2'h0;
  localparam logic [ADDR_W-1:0] OFS_CSA = 2'h1;
  localparam logic [ADDR_W-1:0] OFS_CSB = 2'h2;
  localparam logic [ADDR_W-1:0] OFS_CSC = 2'h3;

  // ==========================================================================
  // field positions
  localparam int A_RXC = 7;
  localparam int A_TXC = 6;
  localparam int A_UDRE = 5;
  localparam int A_FE = 4;
  localparam int A_DOR = 3;
  localparam int A_UPE = 2;
  localparam int B_TXCIE = 6;
  localparam int B_UDRIE = 5;
  localparam int B_RXEN = 4;
  localparam int B_TXEN = 3;
  localparam int B_SZ2 = 2;
  localparam int B_RX9 = 1;
  localparam int B_TX9 = 0;
  localparam int C_SYNC = 6;
  localparam int C_PAR_HI = 5;
  localparam int C_PAR_LO = 4;
  localparam int C_STOP2 = 3;
  localparam int C_SZ_HI = 2;
  localparam int C_SZ_LO = 1;

  // ==========================================================================
  // reset values and counts
  localparam logic [DATA_W-1:0] CSB_RST = 8'h00;
  localparam logic [DATA_W-1:0] CSC_RST = 8'h06;
  localparam logic SYNC_RST = 1'b1;
  localparam logic [2:0] SZ_NINE = 3'h7;
  localparam logic [2:0] SZ_LAST_SHORT = 3'h3;
  localparam logic [3:0] LEN_NINE = 4'h9;
  localparam logic [3:0] LEN_EIGHT = 4'h8;
  localparam logic [3:0] LEN_MIN = 4'h5;

  // ==========================================================================
  // types
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic ninth;
    logic fe;
    logic dor;
    logic upe;
    logic [DATA_W-1:0] data;
  } rx_entry_t;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_PAR, RX_STOP} rx_state_t;

endpackage

//--- hdl/sync2.sv
/*
  Two-flop synchroniser for one level coming from a pin.
  Assumes the reset value is the idle level of the line.
*/
module sync2
  import txrx_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic d, // asynchronous level
  output logic q // synchronised level
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= SYNC_RST;
      sync_q <= SYNC_RST;
    end
    else
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule // sync2

//--- hdl/rx_fifo.sv
/*
  Receive buffer: a small FIFO of received frames with their status bits.
  Assumes push is ignored when full and pop ignored when empty.
*/
module rx_fifo
  import txrx_pkg::*;
#(
  parameter int DEPTH = 2
)
(
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset
  input wire logic flush, // empties the buffer
  input wire logic push, // store one frame
  input wire rx_entry_t wentry, // frame to store
  input wire logic pop, // advance to next frame
  output rx_entry_t head, // oldest unread frame
  output logic empty, // no unread frame
  output logic full // no room left
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [PW:0] CNT_FULL = (PW + 1)'(DEPTH);

  rx_entry_t mem_q [DEPTH];
  rx_entry_t mem_d [DEPTH];
  logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [PW:0] cnt_q, cnt_d;
  logic do_push, do_pop;

  assign empty = (cnt_q == '0);
  assign full = (cnt_q == CNT_FULL);
  assign head = mem_q[rp_q];

  always_comb
  begin
    mem_d = mem_q;
    wp_d = wp_q;
    rp_d = rp_q;
    cnt_d = cnt_q;
    do_push = push && !full;
    do_pop = pop && !empty;
    if (do_push)
    begin
      mem_d[wp_q] = wentry;
      wp_d = (wp_q == LAST) ? '0 : wp_q + 1'b1;
    end
    if (do_pop)
      rp_d = (rp_q == LAST) ? '0 : rp_q + 1'b1;
    if (do_push && !do_pop)
      cnt_d = cnt_q + 1'b1;
    else if (do_pop && !do_push)
      cnt_d = cnt_q - 1'b1;
    if (flush)
    begin
      wp_d = '0;
      rp_d = '0;
      cnt_d = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else
    begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end
endmodule // rx_fifo

//--- hdl/serial_txrx_flags_datapath.sv
/*
  Transmit and receive datapath of a serial transceiver with its flag registers.
  Assumes bit_tick comes from a baud unit on core_clk, one pulse per bit period,
  placed mid-bit for reception; in sync mode both sides step on the transfer clock pin.
*/
// How it works
// - buffer-empty flag is high exactly while the transmit buffer holds nothing
// - buffer-empty interrupt requested while flag, its enable and global enable are set
// - writing the data location clears the buffer-empty flag
// - transmit-complete sets when the last stop bit ends and buffer is empty
// - transmit-complete clears when its interrupt is taken
// - writing one clears transmit-complete; writing zero keeps it
// - transmit-complete interrupt raised while flag, enable and global enable are set
// - parity bit sent after last data bit when upper parity bit is one
// - clearing transmit enable waits until buffer and shifter are empty
// - once truly disabled the transmit pin returns to port use
// - receiver enable takes over the receive pin
// - sync mode samples received bits on the transfer clock pin
// - frame begins on a valid start bit, bits shifted until first stop
// - a second stop bit is ignored by the receiver
// - on first stop bit the frame moves into the receive buffer
// - unused upper data bits read as zero for short characters
// - ninth bit and error flags buffered per frame, advanced on data read
// - frame is low start, data lsb first, optional parity, high stops
// - shifter loads when idle or right after the previous last stop bit
// - parity is xor of data bits, inverted for odd parity
module serial_txrx_flags_datapath
  import txrx_pkg::*;
#(
  parameter int RX_DEPTH = 2
)
(
  input wire logic core_clk, // system clock, 20 MHz
  input wire logic rst, // synchronous reset, active high
  input wire bus_req_t bus_req, // register address, data and strobes
  output logic [DATA_W-1:0] rdata, // read data, the cycle after a read strobe
  input wire logic bit_tick, // one-cycle pulse per bit period
  input wire logic global_irq_en, // global interrupt enable
  input wire logic txc_irq_taken, // pulse: transmit-complete interrupt executed
  output logic tx_empty_irq, // buffer-empty interrupt request
  output logic tx_complete_irq, // transmit-complete interrupt request
  output logic txd_o, // transmit pin level
  output logic txd_oe, // transmitter owns the transmit pin
  input wire logic rxd_i, // receive pin
  input wire logic xck_i, // sync_transfer_clock_pin
  output logic rx_pin_owned // receiver owns the receive pin
);
  // ==========================================================================
  // pins and step strobes
  logic rxd_s, xck_s, xck_prev_q;
  logic tx_step, rx_step;

  sync2 u_rxd_sync (.clk(core_clk), .rst(rst), .d(rxd_i), .q(rxd_s));
  sync2 u_xck_sync (.clk(core_clk), .rst(rst), .d(xck_i), .q(xck_s));

  // ==========================================================================
  // control registers
  logic [DATA_W-1:0] csb_q, csb_d, csc_q, csc_d;
  logic wr_data, wr_csa, wr_csb, wr_csc, rd_data;
  logic sync_mode, par_en, par_odd;
  logic [2:0] size_code;
  logic [3:0] len;
  logic [8:0] len_mask;

  function automatic logic [3:0] char_len(input logic [2:0] sz);
    if (sz == SZ_NINE)
      char_len = LEN_NINE;
    else if (sz > SZ_LAST_SHORT)
      char_len = LEN_EIGHT;
    else
      char_len = LEN_MIN + {1'b0, sz};
  endfunction

  assign wr_data = bus_req.wr && bus_req.addr == OFS_DATA;
  assign wr_csa = bus_req.wr && bus_req.addr == OFS_CSA;
  assign wr_csb = bus_req.wr && bus_req.addr == OFS_CSB;
  assign wr_csc = bus_req.wr && bus_req.addr == OFS_CSC;
  assign rd_data = bus_req.rd && bus_req.addr == OFS_DATA;
  assign sync_mode = csc_q[C_SYNC];
  assign par_en = csc_q[C_PAR_HI];
  assign par_odd = csc_q[C_PAR_LO];
  assign size_code = {csb_q[B_SZ2], csc_q[C_SZ_HI:C_SZ_LO]};
  assign len = char_len(size_code);
  assign len_mask = 9'((10'h001 << len) - 10'h001);
  // in sync mode transmit changes on falling, receive samples on rising edge
  assign tx_step = sync_mode ? (xck_prev_q && !xck_s) : bit_tick;
  assign rx_step = sync_mode ? (!xck_prev_q && xck_s) : bit_tick;

  always_comb
  begin
    csb_d = csb_q;
    csc_d = csc_q;
    if (wr_csb)
      csb_d = {bus_req.wdata[7:2], 1'b0, bus_req.wdata[B_TX9]};
    if (wr_csc)
      csc_d = bus_req.wdata;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      csb_q <= CSB_RST;
      csc_q <= CSC_RST;
      xck_prev_q <= SYNC_RST;
    end
    else
    begin
      csb_q <= csb_d;
      csc_q <= csc_d;
      xck_prev_q <= xck_s;
    end
  end

  // ==========================================================================
  // transmitter
  tx_state_t tx_state_q, tx_state_d;
  logic [3:0] tx_cnt_q, tx_cnt_d, tx_nxt;
  logic [8:0] tx_buf_q, tx_buf_d, tx_data_q, tx_data_d;
  logic tx_full_q, tx_full_d, tx_act_q, tx_act_d, txd_q, txd_d;
  logic txc_q, txc_d, txc_set, tx_load, tx_par_bit;
  logic udre_irq_q, udre_irq_d, txc_irq_q, txc_irq_d;

  assign tx_nxt = tx_cnt_q + 4'h1;
  assign tx_par_bit = ^(tx_data_q & len_mask) ^ par_odd;

  always_comb
  begin
    tx_state_d = tx_state_q;
    tx_cnt_d = tx_cnt_q;
    tx_data_d = tx_data_q;
    txd_d = txd_q;
    txc_set = 1'b0;
    tx_load = 1'b0;
    case (tx_state_q)
      TX_IDLE:
        tx_load = tx_full_q && tx_act_q;
      TX_START:
        if (tx_step)
        begin
          tx_state_d = (tx_cnt_q == 4'h0) ? TX_DATA : TX_START;
          tx_cnt_d = '0;
          txd_d = (tx_cnt_q == 4'h0) ? tx_data_q[0] : 1'b0;
        end
      TX_DATA:
        if (tx_step)
        begin
          if (tx_nxt == len)
          begin
            tx_cnt_d = '0;
            tx_state_d = par_en ? TX_PAR : TX_STOP;
            txd_d = par_en ? tx_par_bit : 1'b1;
          end
          else
          begin
            tx_cnt_d = tx_nxt;
            txd_d = tx_data_q[tx_nxt];
          end
        end
      TX_PAR:
        if (tx_step)
        begin
          tx_state_d = TX_STOP;
          txd_d = 1'b1;
        end
      TX_STOP:
        if (tx_step)
        begin
          if (tx_cnt_q == {3'h0, csc_q[C_STOP2]})
          begin
            tx_load = tx_full_q && tx_act_q;
            txc_set = !tx_full_q;
            tx_state_d = TX_IDLE;
          end
          else
            tx_cnt_d = tx_nxt;
        end
      default:
        tx_state_d = TX_IDLE;
    endcase
    if (tx_load)
    begin
      tx_data_d = tx_buf_q;
      tx_state_d = TX_START;
      // from idle the line stays high until the next step, so the start bit is whole
      tx_cnt_d = {3'h0, tx_state_q == TX_IDLE};
      txd_d = (tx_state_q == TX_IDLE);
    end
    // a write in the load cycle is kept: the old character leaves, the new one waits
    tx_buf_d = wr_data ? {csb_q[B_TX9], bus_req.wdata} : tx_buf_q;
    tx_full_d = wr_data || (tx_full_q && !tx_load);
    // enable falls only once buffer and shifter are drained
    tx_act_d = csb_q[B_TXEN] || (tx_act_q && (tx_full_q || tx_state_q != TX_IDLE));
    // set wins over both clears
    txc_d = txc_set || (txc_q && !txc_irq_taken && !(wr_csa && bus_req.wdata[A_TXC]));
    udre_irq_d = csb_q[B_UDRIE] && global_irq_en && !tx_full_q;
    txc_irq_d = csb_q[B_TXCIE] && global_irq_en && txc_q && !txc_irq_taken;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tx_state_q <= TX_IDLE;
      tx_cnt_q <= '0;
      tx_buf_q <= '0;
      tx_data_q <= '0;
      tx_full_q <= 1'b0;
      tx_act_q <= 1'b0;
      txd_q <= 1'b1;
      txc_q <= 1'b0;
      udre_irq_q <= 1'b0;
      txc_irq_q <= 1'b0;
    end
    else
    begin
      tx_state_q <= tx_state_d;
      tx_cnt_q <= tx_cnt_d;
      tx_buf_q <= tx_buf_d;
      tx_data_q <= tx_data_d;
      tx_full_q <= tx_full_d;
      tx_act_q <= tx_act_d;
      txd_q <= txd_d;
      txc_q <= txc_d;
      udre_irq_q <= udre_irq_d;
      txc_irq_q <= txc_irq_d;
    end
  end

  // ==========================================================================
  // receiver
  rx_state_t rx_state_q, rx_state_d;
  logic [3:0] rx_cnt_q, rx_cnt_d;
  logic [8:0] rx_sh_q, rx_sh_d;
  logic rx_upe_q, rx_upe_d, dor_pend_q, dor_pend_d, rx_en_q;
  logic rx_push, rx_full, rx_empty, rx_pop;
  rx_entry_t rx_new, rx_head;

  assign rx_pop = rd_data && !rx_empty;

  always_comb
  begin
    rx_state_d = rx_state_q;
    rx_cnt_d = rx_cnt_q;
    rx_sh_d = rx_sh_q;
    rx_upe_d = rx_upe_q;
    rx_push = 1'b0;
    rx_new = '0;
    dor_pend_d = dor_pend_q;
    case (rx_state_q)
      RX_IDLE:
        if (rx_step && !rxd_s)
        begin
          rx_state_d = RX_DATA;
          rx_cnt_d = '0;
          rx_sh_d = '0;
          rx_upe_d = 1'b0;
        end
      RX_DATA:
        if (rx_step)
        begin
          rx_sh_d[rx_cnt_q] = rxd_s;
          rx_cnt_d = rx_cnt_q + 4'h1;
          if (rx_cnt_q + 4'h1 == len)
            rx_state_d = par_en ? RX_PAR : RX_STOP;
        end
      RX_PAR:
        if (rx_step)
        begin
          rx_upe_d = rxd_s ^ (^rx_sh_q) ^ par_odd;
          rx_state_d = RX_STOP;
        end
      RX_STOP:
        if (rx_step)
        begin
          // back to idle at once: a second stop bit is just idle line
          rx_state_d = RX_IDLE;
          rx_push = !rx_full;
          dor_pend_d = rx_full;
          rx_new = '{ninth: rx_sh_q[8], fe: !rxd_s, dor: dor_pend_q, upe: rx_upe_q,
                     data: rx_sh_q[7:0]};
        end
      default:
        rx_state_d = RX_IDLE;
    endcase
    if (!csb_q[B_RXEN])
    begin
      rx_state_d = RX_IDLE;
      dor_pend_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q <= '0;
      rx_sh_q <= '0;
      rx_upe_q <= 1'b0;
      dor_pend_q <= 1'b0;
      rx_en_q <= 1'b0;
    end
    else
    begin
      rx_state_q <= rx_state_d;
      rx_cnt_q <= rx_cnt_d;
      rx_sh_q <= rx_sh_d;
      rx_upe_q <= rx_upe_d;
      dor_pend_q <= dor_pend_d;
      rx_en_q <= csb_q[B_RXEN];
    end
  end

  rx_fifo #(.DEPTH(RX_DEPTH)) u_rx_fifo (
    .clk(core_clk),
    .rst(rst),
    .flush(!csb_q[B_RXEN]),
    .push(rx_push),
    .wentry(rx_new),
    .pop(rx_pop),
    .head(rx_head),
    .empty(rx_empty),
    .full(rx_full)
  );

  // ==========================================================================
  // read port
  logic [DATA_W-1:0] rdata_q, rdata_d;
  rx_entry_t shown;

  always_comb
  begin
    shown = rx_empty ? '0 : rx_head;
    rdata_d = '0;
    if (bus_req.rd)
      case (bus_req.addr)
        OFS_DATA: rdata_d = shown.data;
        OFS_CSA: rdata_d = {!rx_empty, txc_q, !tx_full_q, shown.fe, shown.dor, shown.upe,
                            2'b00};
        OFS_CSB: rdata_d = {csb_q[7:2], shown.ninth, csb_q[B_TX9]};
        OFS_CSC: rdata_d = csc_q;
        default: rdata_d = '0;
      endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      rdata_q <= '0;
    else
      rdata_q <= rdata_d;
  end

  assign rdata = rdata_q;
  assign tx_empty_irq = udre_irq_q;
  assign tx_complete_irq = txc_irq_q;
  assign txd_o = txd_q;
  assign txd_oe = tx_act_q;
  assign rx_pin_owned = rx_en_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  data_write_full_a: assert property (wr_data |=> tx_full_q)
    else $error("data write did not fill transmit buffer");
  udre_irq_a: assert property (tx_empty_irq == $past(csb_q[B_UDRIE] && global_irq_en
    && !tx_full_q))
    else $error("buffer-empty interrupt wrong");
  txc_set_a: assert property (txc_set |=> txc_q && tx_full_q == $past(wr_data)
    && $past(tx_state_q) == TX_STOP)
    else $error("transmit-complete not set at frame end");
  txc_clear_a: assert property (txc_q && !txc_set && (txc_irq_taken || (wr_csa &&
    bus_req.wdata[A_TXC])) |=> !txc_q)
    else $error("transmit-complete not cleared");
  txc_keep_a: assert property (txc_q && !txc_irq_taken
    && !(wr_csa && bus_req.wdata[A_TXC]) |=> txc_q)
    else $error("transmit-complete lost");
  txc_irq_a: assert property (txc_set ##1 (csb_q[B_TXCIE] && global_irq_en
    && !txc_irq_taken) |=> tx_complete_irq)
    else $error("transmit-complete interrupt missing");
  parity_bit_a: assert property (tx_state_q == TX_PAR |-> par_en && txd_q == tx_par_bit)
    else $error("parity bit wrong");
  frame_shape_a: assert property ((tx_state_q == TX_IDLE |-> txd_q) and
    (tx_state_q == TX_START |-> txd_q == (tx_cnt_q != 4'h0)))
    else $error("start or idle level wrong");
  tx_hold_a: assert property (tx_state_q != TX_IDLE || tx_full_q |-> txd_oe)
    else $error("transmitter released early");
  rx_own_a: assert property (rx_pin_owned == $past(csb_q[B_RXEN]))
    else $error("receive pin ownership wrong");
  rx_push_a: assert property (rx_state_q == RX_STOP && rx_step && csb_q[B_RXEN]
    && !rx_full |=> !rx_empty)
    else $error("frame not buffered");
  short_mask_a: assert property (rd_data && len < LEN_EIGHT |=>
    (rdata & ~len_mask[7:0]) == 8'h00)
    else $error("upper bits of short character not zero");

  cover_back_to_back_c: cover property (tx_state_q == TX_STOP && tx_load);
  cover_parity_tx_c: cover property (tx_state_q == TX_PAR ##[1:1000] txc_set);
  cover_rx_frame_c: cover property (rx_push ##[1:20] rd_data);
  cover_overrun_c: cover property (rx_push && rx_new.dor);
endmodule // serial_txrx_flags_datapath

//--- tb/remote_link.sv
/*
  Far-side serial model: drives the receive line and captures transmit frames.
  Assumes tick pulses every 8 core cycles and the device's transmit line
  changes just after a tick, so sampling 4 cycles in lands mid-bit.
*/
module remote_link
(
  input wire logic clk, // system clock
  input wire logic tick, // bit period pulse
  input wire logic txd, // line from device
  output logic rxd // line into device
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle line is high between frames
  initial rxd = 1'b1;

  // ==========================================================================
  // capture one frame: data, optional parity, first stop
  task automatic get_frame(input int nb, output logic [9:0] v);
    v = '0;
    @(posedge clk iff txd === 1'b0);
    repeat (4) @(posedge clk);
    for (int j = 0; j < nb; j++)
    begin
      repeat (8) @(posedge clk);
      v[j] = txd;
    end
  endtask

  // ==========================================================================
  // send one frame; bp flips parity, bs sends a low stop
  task automatic put_frame(input logic [8:0] d, input int n, input logic pen, odd, bp, bs);
    logic p;
    p = ^(d & 9'((1 << n) - 1)) ^ odd ^ bp;
    @(posedge clk iff tick) rxd <= 1'b0;
    for (int j = 0; j < n; j++)
    begin
      @(posedge clk iff tick) rxd <= d[j];
    end
    if (pen)
    begin
      @(posedge clk iff tick) rxd <= p;
    end
    @(posedge clk iff tick) rxd <= ~bs;
    // back high before the idle sample, else a false start follows
    @(posedge clk iff tick) rxd <= 1'b1;
    @(posedge clk iff tick);
  endtask
endmodule // remote_link

//--- tb/serial_txrx_flags_datapath_bench.sv
/*
  Self-checking bench of the transceiver datapath: flags, transmit frames,
  receive buffering and interrupt requests.
  Assumes remote_link on the line side and a bit tick every 8 cycles.
*/
module serial_txrx_flags_datapath_bench
  import txrx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic bit_tick = 1'b0;
  logic global_irq_en = 1'b1;
  logic txc_irq_taken = 1'b0;
  logic xck_i = 1'b0;
  bus_req_t bus_req = '0;
  logic [DATA_W-1:0] rdata;
  logic tx_empty_irq, tx_complete_irq, txd_o, txd_oe, rx_pin_owned, rxd_i;
  int miscompares = 0;
  int check_count = 0;
  int tc = 0;

  always #25 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    tc <= (tc == 7) ? 0 : tc + 1;
    bit_tick <= (tc == 7);
    // transfer clock runs free; only sync mode listens to it
    xck_i <= (tc < 4);
  end

  serial_txrx_flags_datapath #(.RX_DEPTH(2)) dut (
    .core_clk(core_clk), .rst(rst), .bus_req(bus_req), .rdata(rdata), .bit_tick(bit_tick),
    .global_irq_en(global_irq_en), .txc_irq_taken(txc_irq_taken),
    .tx_empty_irq(tx_empty_irq), .tx_complete_irq(tx_complete_irq), .txd_o(txd_o),
    .txd_oe(txd_oe), .rxd_i(rxd_i), .xck_i(xck_i), .rx_pin_owned(rx_pin_owned));

  remote_link link (.clk(core_clk), .tick(bit_tick), .txd(txd_o), .rxd(rxd_i));

  // ==========================================================================
  // helpers
  task automatic chk(input logic [9:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus_req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [1:0] a, input logic [7:0] e);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus_req.rd <= 1'b0;
    @(negedge core_clk);
    chk(rdata, e);
  endtask

  function automatic logic [9:0] frame_exp(input logic [8:0] d, input int n, input logic pen, odd);
    logic [9:0] v;
    v = 10'(d) & ((10'h001 << n) - 10'h001);
    if (pen)
      v[n] = ^v ^ odd;
    v[n + pen] = 1'b1;
    return v;
  endfunction

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    tally_and_finish();
  end

  // ==========================================================================
  // main sequence
  initial
  begin
    logic [9:0] fa, fb;
    logic [7:0] da, db;
    logic [8:0] dq [2];
    logic bp [2];
    logic bs [2];
    logic pen, odd, t9;
    logic [2:0] sz;
    int n;
    void'($urandom(32'h2d82));
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    rchk(OFS_CSB, 8'h00);
    rchk(OFS_CSC, 8'h06);
    chk(txd_o, 1'b1);
    chk(txd_oe, 1'b0);
    // transmit: nine bits no parity, then even, odd; last pass disables with frames pending
    for (int i = 0; i < 3; i++)
    begin
      n = (i == 0) ? 9 : 5 + $urandom % 4;
      sz = (n == 9) ? 3'h7 : 3'(n - 5);
      pen = (i > 0);
      odd = (i == 2);
      t9 = 1'($urandom);
      wr(OFS_CSC, {2'b00, pen, odd, 1'b0, sz[1:0], 1'b0});
      // ninth bit goes in before the low bits
      wr(OFS_CSB, {5'b01001, sz[2], 1'b0, t9});
      da = 8'($urandom);
      db = 8'($urandom);
      fork
        begin
          link.get_frame(n + pen + 1, fa);
          link.get_frame(n + pen + 1, fb);
        end
        begin
          wr(OFS_DATA, da);
          repeat (2) @(posedge core_clk);
          wr(OFS_DATA, db);
          if (i == 2)
            wr(OFS_CSB, 8'h40);
          rchk(OFS_CSA, 8'h00);
          chk(txd_oe, 1'b1);
        end
      join
      chk(fa, frame_exp({t9, da}, n, pen, odd));
      chk(fb, frame_exp({t9, db}, n, pen, odd));
      repeat (8) @(posedge core_clk);
      rchk(OFS_CSA, 8'h60);
      chk(tx_complete_irq, 1'b1);
      if (i == 2)
        chk(txd_oe, 1'b0);
      if (i == 0)
      begin
        @(posedge core_clk);
        txc_irq_taken <= 1'b1;
        @(posedge core_clk);
        txc_irq_taken <= 1'b0;
      end
      else
      begin
        wr(OFS_CSA, 8'h00);
        rchk(OFS_CSA, 8'h60);
        wr(OFS_CSA, 8'h40);
      end
      rchk(OFS_CSA, 8'h20);
      chk(tx_complete_irq, 1'b0);
    end
    // receive: sizes 5 to 9, random parity and line faults, third pass in sync mode
    wr(OFS_CSB, 8'h10);
    repeat (3) @(negedge core_clk);
    chk(rx_pin_owned, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      n = (k == 0) ? 5 : (k == 3) ? 9 : 6 + $urandom % 3;
      sz = (n == 9) ? 3'h7 : 3'(n - 5);
      pen = 1'($urandom);
      odd = 1'($urandom);
      wr(OFS_CSB, {3'b000, 1'b1, 1'b0, sz[2], 2'b00});
      wr(OFS_CSC, {1'b0, (k == 2), pen, odd, 1'b0, sz[1:0], 1'b0});
      for (int f = 0; f < 2; f++)
      begin
        dq[f] = 9'($urandom);
        bp[f] = 1'($urandom);
        bs[f] = 1'($urandom);
        link.put_frame(dq[f], n, pen, odd, bp[f], bs[f]);
      end
      for (int f = 0; f < 2; f++)
      begin
        rchk(OFS_CSA, {3'b101, bs[f], 1'b0, bp[f] & pen, 2'b00});
        if (n == 9)
          rchk(OFS_CSB, {3'b000, 1'b1, 1'b0, 1'b1, dq[f][8], 1'b0});
        rchk(OFS_DATA, dq[f][7:0] & 8'((16'h0001 << n) - 1));
      end
      rchk(OFS_CSA, 8'h20);
    end
    // overrun: frame 2 meets a full buffer and is lost, frame 3 carries the flag
    for (int f = 0; f < 4; f++)
    begin
      if (f == 3)
        rchk(OFS_DATA, 8'h00);
      link.put_frame(9'(f), n, pen, odd, 1'b0, 1'b0);
    end
    rchk(OFS_DATA, 8'h01);
    rchk(OFS_CSA, 8'ha8);
    rchk(OFS_DATA, 8'h03);
    // buffer-empty request follows its enable and the global enable
    wr(OFS_CSB, 8'h20);
    repeat (3) @(negedge core_clk);
    chk(tx_empty_irq, 1'b1);
    chk(rx_pin_owned, 1'b0);
    @(posedge core_clk);
    global_irq_en <= 1'b0;
    repeat (3) @(negedge core_clk);
    chk(tx_empty_irq, 1'b0);
    tally_and_finish();
  end
endmodule // serial_txrx_flags_datapath_bench
